// ==== rtl/csi_core_ctrl.sv ====
//------------------------------------------------------------
// Purpose: status flags, register file, stack pointer, interrupt entry
// Assumes: decoder presents operand addresses one cycle ahead
// Notes  : outputs are all registered
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module csi_core_ctrl
  import csi_pkg::*;
(
  input  wire logic             mclk,        // cpu clock, undivided
  input  wire logic             rstn,        // async reset, low
  input  wire csi_exec_t        ex_i,        // executing op
  input  wire logic [4:0]       rd_a_i,      // operand a address (fetch)
  input  wire logic [4:0]       rd_b_i,      // operand b address (fetch)
  input  wire csi_dacc_t        dacc_i,      // data-space access
  input  wire csi_ptr_t         ptr_i,       // pointer request
  input  wire logic [NSRC-1:0]  req_set_i,   // flag-type event pulses
  input  wire logic [NSRC-1:0]  req_lvl_i,   // level-type conditions
  input  wire logic [NSRC-1:0]  req_en_i,    // individual enables
  output logic [7:0]            op_a_o,      // operand a
  output logic [7:0]            op_b_o,      // operand b
  output logic [7:0]            rdata_o,     // data-space read data
  output logic [15:0]           ptr_addr_o,  // pointer address
  output logic [15:0]           sp_o,        // stack pointer
  output logic [7:0]            processor_status_flags_o,      // status flags
  output logic                  tbit_o,      // copy bit for loads
  output logic                  irq_take_o,  // entry started
  output logic [15:0]           irq_vec_o,   // vector address
  output logic                  core_busy_o  // entry/return sequence
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    csi_fsm_t           fsm;
    logic [2:0]         cnt;
    logic               inhib;   // hold off one instruction
    logic               vector_table_select;   // vector table select
    logic [7:0]         processor_status_flags;
    logic [15:0]        sp;
    logic [31:0][7:0]   rf;
    logic [NSRC-1:0]    flg;     // latched request flags
    logic [7:0]         opa;
    logic [7:0]         opb;
    logic [7:0]         rdata;
    logic [15:0]        paddr;
    logic               take;
    logic [15:0]        vec;
    logic               busy;
  } csi_st_t;

  csi_st_t q_r;   // registered state
  csi_st_t d_nxt; // next state

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // lowest pending index wins, as its vector is lowest
  function automatic logic [2:0] first_idx(input logic [NSRC-1:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // vector address; slot zero is reset
  function automatic logic [15:0] vec_of(input logic [2:0] i, input logic sel);
    logic [15:0] b;
    b = sel ? BOOT_BASE : 16'h0000;
    return 16'(b + 16'(({13'h0, i} + 16'h0001) * VEC_STEP));
  endfunction

  // sign bit always follows negative xor overflow
  function automatic logic [7:0] fix_sign(input logic [7:0] s);
    logic [7:0] r;
    r = s;
    r[SGN_B] = s[NEG_B] ^ s[OVF_B];
    return r;
  endfunction

  logic [NSRC-1:0] pend;     // enabled requests
  logic [2:0]      win;      // winning source
  logic [15:0]     pv;       // selected pointer value
  logic [4:0]      pr;       // pointer low register
  logic            set_inh;  // set-enable in this cycle starts a hold-off

  // ----------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------
  always_comb begin
    d_nxt   = q_r;
    set_inh = 1'b0;
    d_nxt.take = 1'b0;
    // latched flags plus live levels; a vanished level is gone
    pend = ((q_r.flg & ~LEVEL_SRC) | (req_lvl_i & LEVEL_SRC)) & req_en_i;
    win  = first_idx(pend);
    pr   = 5'(PTR_BASE + {ptr_i.sel, 1'b0});
    pv   = {q_r.rf[pr + 5'h01], q_r.rf[pr]};

    // operand reads from the registered file, without write-back forwarding, one cycle alu
    d_nxt.opa = q_r.rf[rd_a_i];
    d_nxt.opb = q_r.rf[rd_b_i];

    // alu flag update after every alu op
    if (ex_i.op == OP_ALU) begin
      if (ex_i.fmask[4]) d_nxt.processor_status_flags[HCY_B] = ex_i.fval[4];
      if (ex_i.fmask[3]) d_nxt.processor_status_flags[OVF_B] = ex_i.fval[3];
      if (ex_i.fmask[2]) d_nxt.processor_status_flags[NEG_B] = ex_i.fval[2];
      if (ex_i.fmask[1]) d_nxt.processor_status_flags[ZER_B] = ex_i.fval[1];
      if (ex_i.fmask[0]) d_nxt.processor_status_flags[CRY_B] = ex_i.fval[0];
    end

    // register write-back, byte or pair
    if (ex_i.wb_en) begin
      d_nxt.rf[ex_i.wb_reg] = ex_i.wb_data[7:0];
      if (ex_i.wb16) d_nxt.rf[ex_i.wb_reg + 5'h01] = ex_i.wb_data[15:8];
    end

    // copy bit store and load
    if (ex_i.op == OP_BST) begin
      d_nxt.processor_status_flags[TCP_B] = q_r.rf[ex_i.wb_reg][ex_i.bit_sel];
    end else if (ex_i.op == OP_BLD) begin
      d_nxt.rf[ex_i.wb_reg][ex_i.bit_sel] = q_r.processor_status_flags[TCP_B];
    end

    // data-space access: register file, then i/o registers
    d_nxt.rdata = 8'h00;
    if (dacc_i.en) begin
      if (dacc_i.addr <= RF_TOP) begin
        d_nxt.rdata = q_r.rf[dacc_i.addr[4:0]];
        if (dacc_i.we) d_nxt.rf[dacc_i.addr[4:0]] = dacc_i.wdata;
      end else if (dacc_i.addr == IO_BASE + 16'(IO_SPL)) begin
        d_nxt.rdata = q_r.sp[7:0];
        if (dacc_i.we) d_nxt.sp[7:0] = dacc_i.wdata;
      end else if (dacc_i.addr == IO_BASE + 16'(IO_SPH)) begin
        d_nxt.rdata = q_r.sp[15:8];
        if (dacc_i.we) d_nxt.sp[15:8] = dacc_i.wdata;
      end else if (dacc_i.addr == IO_BASE + 16'(IO_PROCESSOR_STATUS_FLAGS)) begin
        d_nxt.rdata = q_r.processor_status_flags;
        if (dacc_i.we) d_nxt.processor_status_flags = dacc_i.wdata;
      end else if (dacc_i.addr == IO_BASE + 16'(IO_CORECTL)) begin
        d_nxt.rdata = {6'h00, q_r.vector_table_select, 1'b0};
        if (dacc_i.we) d_nxt.vector_table_select = dacc_i.wdata[VTS_B];
      end else if (dacc_i.addr == IO_BASE + 16'(IO_REQFLG)) begin
        d_nxt.rdata = q_r.flg;
        if (dacc_i.we) d_nxt.flg = q_r.flg & ~dacc_i.wdata;
      end
    end

    // pointer addressing: displacement, post-inc, pre-dec
    if (ptr_i.en) begin
      case (ptr_i.mode)
        PM_DISP: d_nxt.paddr = 16'(pv + {10'h000, ptr_i.disp});
        PM_INC: begin
          d_nxt.paddr = pv;
          {d_nxt.rf[pr + 5'h01], d_nxt.rf[pr]} = 16'(pv + 16'h0001);
        end
        PM_DEC: begin
          d_nxt.paddr = 16'(pv - 16'h0001);
          {d_nxt.rf[pr + 5'h01], d_nxt.rf[pr]} = 16'(pv - 16'h0001);
        end
        default: d_nxt.paddr = pv;
      endcase
    end

    // stack pointer and enable ops
    case (ex_i.op)
      OP_PUSH: d_nxt.sp = 16'(d_nxt.sp - 16'h0001);
      OP_POP:  d_nxt.sp = 16'(d_nxt.sp + 16'h0001);
      OP_CALL: d_nxt.sp = 16'(d_nxt.sp - 16'h0002);
      OP_RET:  d_nxt.sp = 16'(d_nxt.sp + 16'h0002);
      OP_RETURN_FROM_INTERRUPT_OP: begin
        d_nxt.sp  = 16'(d_nxt.sp + 16'h0002);
        d_nxt.fsm = ST_RET;
        d_nxt.cnt = 3'(RET_CYC - 3'h1);
      end
      OP_SEI: begin
        d_nxt.processor_status_flags[GIE_B] = 1'b1;
        set_inh = 1'b1;
      end
      OP_CLI: d_nxt.processor_status_flags[GIE_B] = 1'b0;
      default: ;
    endcase

    // hold-off lasts until the next instruction boundary
    if (ex_i.done && !set_inh) d_nxt.inhib = 1'b0;
    if (set_inh) d_nxt.inhib = 1'b1;

    // interrupt sequencing
    case (q_r.fsm)
      ST_RUN: begin
        // cli of this cycle already cleared d_nxt.processor_status_flags, so it blocks
        if (ex_i.done && d_nxt.processor_status_flags[GIE_B] && !q_r.inhib && !set_inh &&
            (pend != '0) && ex_i.op != OP_RETURN_FROM_INTERRUPT_OP && ex_i.op != OP_CALL) begin
          d_nxt.take        = 1'b1;
          d_nxt.vec         = vec_of(win, q_r.vector_table_select);
          d_nxt.processor_status_flags[GIE_B] = 1'b0;
          d_nxt.sp          = 16'(d_nxt.sp - 16'h0002);
          d_nxt.fsm         = ST_ENTRY;
          d_nxt.cnt         = 3'(ENTRY_CYC - 3'h1);
          d_nxt.flg[win]    = 1'b0;
        end
      end
      ST_ENTRY: begin
        if (q_r.cnt == 3'h0) d_nxt.fsm = ST_RUN;
        else d_nxt.cnt = 3'(q_r.cnt - 3'h1);
      end
      ST_RET: begin
        if (q_r.cnt == 3'h0) begin
          d_nxt.fsm         = ST_RUN;
          d_nxt.processor_status_flags[GIE_B] = 1'b1;
          d_nxt.inhib       = 1'b1;
        end else begin
          d_nxt.cnt = 3'(q_r.cnt - 3'h1);
        end
      end
      default: d_nxt.fsm = ST_RUN;
    endcase

    // new events win over any clear in the same cycle
    d_nxt.flg  = d_nxt.flg | (req_set_i & ~LEVEL_SRC);
    d_nxt.processor_status_flags = fix_sign(d_nxt.processor_status_flags);
    d_nxt.busy = (d_nxt.fsm != ST_RUN);
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q_r       <= '0;
      q_r.fsm   <= ST_RUN;
      q_r.processor_status_flags  <= PROCESSOR_STATUS_FLAGS_RST;
      q_r.sp    <= TOP_OF_RAM;
    end else begin
      q_r <= d_nxt;
    end
  end

  assign op_a_o      = q_r.opa;
  assign op_b_o      = q_r.opb;
  assign rdata_o     = q_r.rdata;
  assign ptr_addr_o  = q_r.paddr;
  assign sp_o        = q_r.sp;
  assign processor_status_flags_o      = q_r.processor_status_flags;
  assign tbit_o      = q_r.processor_status_flags[TCP_B];
  assign irq_take_o  = q_r.take;
  assign irq_vec_o   = q_r.vec;
  assign core_busy_o = q_r.busy;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  take_clears_a: assert property (irq_take_o |-> !processor_status_flags_o[GIE_B])
    else $error("enable not cleared on entry");
  take_gated_a: assert property (irq_take_o |-> $past(processor_status_flags_o[GIE_B]))
    else $error("interrupt taken while disabled");
  sign_xor_a: assert property (processor_status_flags_o[SGN_B] == (processor_status_flags_o[NEG_B] ^ processor_status_flags_o[OVF_B]))
    else $error("sign bit mismatch");
  push_step_a: assert property (
    (ex_i.op == OP_PUSH && !dacc_i.en && q_r.fsm == ST_RUN && !d_nxt.take)
    |=> sp_o == 16'($past(sp_o) - 16'h0001))
    else $error("push did not step stack by one");
  pop_step_a: assert property (
    (ex_i.op == OP_POP && !dacc_i.en && q_r.fsm == ST_RUN && !d_nxt.take)
    |=> sp_o == 16'($past(sp_o) + 16'h0001))
    else $error("pop did not step stack by one");
  call_step_a: assert property (
    (ex_i.op == OP_CALL && !dacc_i.en)
    |=> sp_o == 16'($past(sp_o) - 16'h0002))
    else $error("call did not step stack by two");
  ret_step_a: assert property (
    (ex_i.op == OP_RET && !dacc_i.en && q_r.fsm == ST_RUN && !d_nxt.take)
    |=> sp_o == 16'($past(sp_o) + 16'h0002))
    else $error("return did not step stack by two");
  entry_len_a: assert property (irq_take_o |-> core_busy_o[*4] ##1 !core_busy_o)
    else $error("entry sequence length wrong");
  busy_gate_a: assert property (core_busy_o |=> !irq_take_o)
    else $error("interrupt taken during a sequence");
  return_from_interrupt_op_len_a: assert property (
    (ex_i.op == OP_RETURN_FROM_INTERRUPT_OP && q_r.fsm == ST_RUN)
    |=> core_busy_o[*4] ##1 (!core_busy_o && processor_status_flags_o[GIE_B]))
    else $error("return sequence wrong");
  // a new event must survive any clear that lands in the same cycle
  flag_latch_a: assert property (
    (req_set_i != '0) |=> ((q_r.flg & $past(req_set_i & ~LEVEL_SRC)) == $past(req_set_i & ~LEVEL_SRC)))
    else $error("request event not latched");
  bst_copy_a: assert property (
    (ex_i.op == OP_BST && !dacc_i.en) |=> tbit_o == $past(q_r.rf[ex_i.wb_reg][ex_i.bit_sel]))
    else $error("copy bit not stored");
  cli_now_a: assert property (ex_i.op == OP_CLI |=> !irq_take_o)
    else $error("interrupt after clear-enable");
  sei_hold_a: assert property ((ex_i.op == OP_SEI && ex_i.done) |-> ##1 !irq_take_o ##1 !irq_take_o)
    else $error("interrupt right after set-enable");

  take_cv: cover property (irq_take_o ##[1:20] (ex_i.op == OP_RETURN_FROM_INTERRUPT_OP));
  nest_cv: cover property (irq_take_o ##[1:20] irq_take_o);
  ptr_cv:  cover property (ptr_i.en && ptr_i.mode == PM_DEC);

endmodule : csi_core_ctrl
`default_nettype wire

// ==== rtl/csi_pkg.sv ====
//------------------------------------------------------------
// Purpose: shared constants and types for the core status block
// Assumes: one 20 MHz clock, decoder drives one op per cycle
// Notes  : offsets are I/O offsets; data space adds IO_BASE
//------------------------------------------------------------
// Notes on behaviour
// - no interrupt while global enable bit clear
// - taking clears enable; return sets it again
// - bit six holds bit store and load
// - half carry bit five, overflow bit three
// - sign bit is negative xor overflow
// - negative bit two, zero one, carry zero
// - flags updated after every alu operation
// - working registers at data addresses 0x00-0x1f
// - three pointer pairs at 0x1a-0x1f, low first
// - push decrements pointer, pop increments, by one
// - call/interrupt minus two, returns plus two
// - stack pointer bytes at 0x3e/0x3d, reset top
// - undivided clock, one cycle register alu op
// - lower vector wins; reset, then request zero
// - vector select bit moves table to boot
// - hardware clears flag on vectoring; write-one clears
// - flags latch while disabled, served by priority
// - level requests only while condition persists
// - one instruction runs after return before interrupts
// - clear-enable blocks even same-cycle requests
// - entry takes four cycles, after instruction completes
// - return takes four cycles, sets enable
// - one instruction runs after set-enable
package csi_pkg;

  // ----------------------------------------------------------
  // status flag bit positions
  // ----------------------------------------------------------
  localparam int GIE_B = 7;
  localparam int TCP_B = 6;
  localparam int HCY_B = 5;
  localparam int SGN_B = 4;
  localparam int OVF_B = 3;
  localparam int NEG_B = 2;
  localparam int ZER_B = 1;
  localparam int CRY_B = 0;

  // ----------------------------------------------------------
  // map and reset values
  // ----------------------------------------------------------
  localparam logic [15:0] IO_BASE     = 16'h0020;
  localparam logic [15:0] RF_TOP      = 16'h001f;
  localparam logic [5:0]  IO_SPL      = 6'h3d;
  localparam logic [5:0]  IO_SPH      = 6'h3e;
  localparam logic [5:0]  IO_PROCESSOR_STATUS_FLAGS     = 6'h3f;
  localparam logic [5:0]  IO_CORECTL  = 6'h35;
  localparam logic [5:0]  IO_REQFLG   = 6'h3c;
  localparam int          VTS_B       = 1;
  localparam logic [4:0]  PTR_BASE    = 5'h1a;
  localparam logic [15:0] TOP_OF_RAM  = 16'h03ff;
  localparam logic [7:0]  PROCESSOR_STATUS_FLAGS_RST    = 8'h00;
  localparam logic [15:0] BOOT_BASE   = 16'h1c00;
  localparam logic [15:0] VEC_STEP    = 16'h0002;
  localparam int          NSRC        = 8;
  localparam logic [7:0]  LEVEL_SRC   = 8'h00;
  localparam logic [2:0]  ENTRY_CYC   = 3'h4;
  localparam logic [2:0]  RET_CYC     = 3'h4;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ALU = 4'h1, OP_PUSH = 4'h2, OP_POP = 4'h3,
    OP_CALL = 4'h4, OP_RET = 4'h5, OP_RETURN_FROM_INTERRUPT_OP = 4'h6, OP_SEI = 4'h7,
    OP_CLI = 4'h8, OP_BST = 4'h9, OP_BLD = 4'ha
  } csi_op_t;

  typedef enum logic [1:0] {
    PM_PLAIN = 2'h0, PM_DISP = 2'h1, PM_INC = 2'h2, PM_DEC = 2'h3
  } csi_pmode_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001, ST_ENTRY = 3'b010, ST_RET = 3'b100
  } csi_fsm_t;

  // one executed operation with its alu outcome and write-back
  typedef struct packed {
    csi_op_t     op;
    logic        done;      // instruction boundary this cycle
    logic [4:0]  fmask;     // which of h,v,n,z,c the op writes
    logic [4:0]  fval;      // h,v,n,z,c values
    logic        wb_en;
    logic        wb16;      // pair write to wb_reg/wb_reg+1
    logic [4:0]  wb_reg;
    logic [15:0] wb_data;
    logic [2:0]  bit_sel;   // bit for store/load
  } csi_exec_t;

  // data-space access from the load/store path
  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } csi_dacc_t;

  // pointer address generation
  typedef struct packed {
    logic        en;
    logic [1:0]  sel;       // 0,1,2 -> pair at 0x1a,0x1c,0x1e
    csi_pmode_t  mode;
    logic [5:0]  disp;
  } csi_ptr_t;

endpackage : csi_pkg

// ==== testbench/csi_src_model.sv ====
// Purpose: request source model facing the status block
// Assumes: the bench commands one event mask per cycle
// Notes  : every source is flag type, so no level conditions
`timescale 1ns/1ps
`default_nettype none
module csi_src_model
  import csi_pkg::*;
(
  input  wire logic [NSRC-1:0] fire_i, // bench event command
  input  wire logic            rstn,   // no events during reset
  output logic [NSRC-1:0]      set_o,  // event pulses
  output logic [NSRC-1:0]      lvl_o   // level conditions
);
  // events fire whatever the enables hold; latching is the device's job
  assign set_o = rstn ? fire_i : '0;
  // no level condition is ever present, so none may trigger
  assign lvl_o = '0;
endmodule // csi_src_model
`default_nettype wire

// ==== testbench/tb_csi_core_ctrl.sv ====
// Purpose: self-checking bench for the core status block
// Assumes: one op per cycle, bus read answers next cycle
// Notes  : idle cycles carry no instruction boundary
`timescale 1ns/1ps
`default_nettype none
module tb_csi_core_ctrl
  import csi_pkg::*;
;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic            mclk, rstn;               // clock and reset
  csi_exec_t       ex;                       // executing op
  logic [4:0]      rd_a, rd_b;               // operand addresses
  csi_dacc_t       dacc;                     // data access
  csi_ptr_t        ptr;                      // pointer request
  logic [NSRC-1:0] fire, req_set, req_lvl;   // event command and lines
  logic [NSRC-1:0] req_en;                   // individual enables
  logic [7:0]      op_a, op_b, rdata, processor_status_flags;  // byte outputs
  logic [15:0]     ptr_addr, sp, vec;        // word outputs
  logic            tbit, take, busy;         // flags
  int              fails = 0;                // mismatches
  int              cmp_count = 0;            // comparisons
  int              take_cnt = 0;             // entry pulses seen
  int              busy_cnt = 0;             // busy cycles seen
  logic [15:0]     esp;                      // expected stack pointer
  logic [4:0]      fvt [6] = '{5'h1f, 5'h08, 5'h04, 5'h0c, 5'h13, 5'h00};
  csi_op_t         sop [4] = '{OP_PUSH, OP_POP, OP_CALL, OP_RET};
  logic [15:0]     sdl [4] = '{16'hffff, 16'h0001, 16'hfffe, 16'h0002};

  csi_core_ctrl dut (.mclk(mclk), .rstn(rstn), .ex_i(ex), .rd_a_i(rd_a), .rd_b_i(rd_b),
    .dacc_i(dacc), .ptr_i(ptr), .req_set_i(req_set), .req_lvl_i(req_lvl), .req_en_i(req_en),
    .op_a_o(op_a), .op_b_o(op_b), .rdata_o(rdata), .ptr_addr_o(ptr_addr), .sp_o(sp),
    .processor_status_flags_o(processor_status_flags), .tbit_o(tbit), .irq_take_o(take), .irq_vec_o(vec), .core_busy_o(busy));
  csi_src_model src (.fire_i(fire), .rstn(rstn), .set_o(req_set), .lvl_o(req_lvl));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // counts sample the value from before each edge, so read them late
  always @(posedge mclk) begin
    if (take === 1'b1) take_cnt++;
    if (busy === 1'b1) busy_cnt++;
  end

  // ----------------------------------------------------------
  // compare and access tasks
  // ----------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write is held one edge, then released on a later edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    dacc <= '{1'b1, 1'b1, a, d};
    @(posedge mclk);
    dacc <= '0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk);
    dacc <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge mclk);
    dacc <= '0;
    #1 chk8(nm, e, rdata);
  endtask
  // op stays on ex until the next op or idle overwrites it
  task automatic op(input csi_op_t o, input logic [7:0] f = '0, input logic [4:0] fv = '0,
                    input logic [4:0] r = '0, input logic [2:0] b = '0);
    csi_exec_t e;
    e = '0;
    e.op = o;
    e.done = 1'b1;
    e.fmask = (o == OP_ALU) ? 5'h1f : 5'h00;
    e.fval = fv;
    e.wb_reg = r;
    e.bit_sel = b;
    @(posedge mclk);
    ex <= e;
    fire <= f;
  endtask
  task automatic idle();
    @(posedge mclk);
    ex <= '0;
    fire <= '0;
  endtask
  task automatic pt(input csi_pmode_t m, input logic [5:0] d, input logic [15:0] x, input string nm);
    @(posedge mclk);
    ptr <= '{1'b1, 2'd0, m, d};
    @(posedge mclk);
    ptr <= '0;
    #1 chk16(nm, x, ptr_addr);
  endtask
  task automatic enter(input logic [15:0] v);
    int b0;
    op(OP_NONE);
    #1 chk8("early take", 8'h00, {7'h0, take});
    op(OP_NONE);
    #1 chk8("held take", 8'h00, {7'h0, take});
    idle();
    #1;
    b0 = busy_cnt;
    esp = esp - 16'h0002;
    chk8("take", 8'h01, {7'h0, take});
    chk16("vector", v, vec);
    chk16("sp entry", esp, sp);
    chk8("gie off", 8'h00, {7'h0, processor_status_flags[GIE_B]});
    repeat (6) @(posedge mclk);
    chk16("entry busy", 16'h0004, 16'(busy_cnt - b0));
    rc(16'h005f, 8'h40, "flags saved");
  endtask
  task automatic ret_irq();
    int b0;
    b0 = busy_cnt;
    op(OP_RETURN_FROM_INTERRUPT_OP);
    idle();
    repeat (6) @(posedge mclk);
    #1;
    esp = esp + 16'h0002;
    chk16("sp return_from_interrupt_op", esp, sp);
    chk16("return_from_interrupt_op busy", 16'h0004, 16'(busy_cnt - b0));
    chk8("gie on", 8'h01, {7'h0, processor_status_flags[GIE_B]});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    {rstn, ex, rd_a, rd_b, dacc, ptr, fire} = '0;
    req_en = 8'hff;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    esp = TOP_OF_RAM;
    #1 chk16("sp reset", esp, sp);
    rc(16'h005f, 8'h00, "flags reset");
    rc(16'h005d, 8'hff, "sp low reset");
    rc(16'h005e, 8'h03, "sp high reset");
    rc(16'h0060, 8'h00, "unmapped");
    wr(16'h005e, 8'h04);
    wr(16'h005d, 8'hff);
    esp = 16'h04ff;
    rc(16'h005e, 8'h04, "sp high");
    for (int i = 0; i < 4; i++) begin
      op(sop[i]);
      idle();
      esp = esp + sdl[i];
      #1 chk16("sp step", esp, sp);
    end
    $display("test stack done");
    for (int i = 0; i < 6; i++) begin
      op(OP_ALU, '0, fvt[i]);
      idle();
      #1 chk8("alu flags", {2'b00, fvt[i][4], fvt[i][2] ^ fvt[i][3], fvt[i][3:0]}, processor_status_flags);
    end
    $display("test flags done");
    wr(16'h001a, 8'h34);
    wr(16'h001b, 8'h12);
    @(posedge mclk);
    rd_a <= 5'h1b;
    rd_b <= 5'h1a;
    @(posedge mclk);
    #1 chk8("operand a", 8'h12, op_a);
    chk8("operand b", 8'h34, op_b);
    pt(PM_PLAIN, 6'h00, 16'h1234, "ptr plain");
    pt(PM_DISP, 6'h05, 16'h1239, "ptr disp");
    pt(PM_INC, 6'h00, 16'h1234, "ptr inc");
    pt(PM_PLAIN, 6'h00, 16'h1235, "ptr after inc");
    pt(PM_DEC, 6'h00, 16'h1234, "ptr dec");
    rc(16'h001a, 8'h34, "ptr low byte");
    wr(16'h0010, 8'h80);
    wr(16'h0011, 8'h00);
    op(OP_BST, '0, '0, 5'h10, 3'd7);
    idle();
    #1 chk8("copy bit", 8'h01, {7'h0, tbit});
    op(OP_BLD, '0, '0, 5'h11, 3'd2);
    idle();
    rc(16'h0011, 8'h04, "bit load");
    $display("test registers done");
    op(OP_NONE, 8'h28);
    op(OP_NONE);
    idle();
    repeat (3) @(posedge mclk);
    chk16("no take", 16'h0000, 16'(take_cnt));
    rc(16'h005c, 8'h28, "latched flags");
    op(OP_SEI);
    enter(16'h0008);
    rc(16'h005c, 8'h20, "flag cleared");
    ret_irq();
    enter(16'h000c);
    ret_irq();
    // flag pending and hold-off over by the clear, so only the clear stops it
    op(OP_SEI);
    op(OP_NONE, 8'h02);
    op(OP_CLI, 8'h02);
    op(OP_NONE);
    op(OP_NONE);
    idle();
    repeat (4) @(posedge mclk);
    chk16("cli blocks", 16'h0002, 16'(take_cnt));
    rc(16'h005c, 8'h02, "flag held");
    wr(16'h005c, 8'h02);
    rc(16'h005c, 8'h00, "write one clears");
    wr(16'h0055, 8'h02);
    // individual enable off: the flag must wait although global enable is on
    @(posedge mclk);
    req_en <= 8'hfe;
    op(OP_SEI, 8'h01);
    op(OP_NONE);
    op(OP_NONE);
    idle();
    #1 chk16("enable off", 16'h0002, 16'(take_cnt));
    rc(16'h005c, 8'h01, "flag kept");
    op(OP_CLI);
    req_en <= 8'hff;
    op(OP_SEI);
    enter(BOOT_BASE + 16'h0002);
    ret_irq();
    $display("test interrupts done");
    wrap_up();
  end
endmodule // tb_csi_core_ctrl
`default_nettype wire
